//--- rtl/core_common_regs.sv
// common control and status registers of the serial backplane core
//
// Contract
// - three-bit select picks the channel feeding both error counters; 000 AA, 001 AB
// - mode bit 3 puts channels AA and AB in cell mode
// - mode bit 4 puts channels AC and AD in cell mode
// - mode bit 5 puts channels BA and BB in cell mode
// - mode bit 6 puts channels BC and BD in cell mode
// - mode bit 7 runs eight-link cell mode, ignoring the four pair bits
// - two-bit phase field delays the soft reset by one of four phases
// - reset bit 7 resets core flops but not the software registers
// - soft reset leaves serializer/deserializer registers untouched
// - rising edge of transmit setup bit 7 signals configuration complete
// - each summary bit ORs one channel's alarms; bit 0 BD through bit 7 AA
// - any summary bit set raises the alarm indication to the logic side
// - eight-bit section parity counter counts errors of the selected channel
// - reading the section parity counter returns it and clears it
// - eight-bit cell parity counter counts selected errors, clears on read
`include "core_common_defs.svh"
`default_nettype none
module core_common_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire core_common_pkg::apb_addr_type paddr,
    input wire core_common_pkg::apb_data_type pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output core_common_pkg::apb_data_type prdata,
    output logic pslverr,
    // error events per channel, index 0 is AA, 7 is BD
    input wire logic [7:0] section_error,
    input wire logic [7:0] cell_error,
    // alarm status bits, four per channel, channel AA lowest
    input wire logic [31:0] alarm_status,
    // core control
    output logic [3:0] cell_pair_enable,
    output logic cell_all_enable,
    output logic core_soft_reset,
    output logic tx_setup_done,
    output logic alarm_indication,
    // interrupt
    output logic irq
);
    import core_common_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers and wires

    reg8_type select_mode;
    logic [2:0] reset_ctrl;
    logic tx_done_bit;
    logic tx_done_prev;
    reg8_type section_count;
    reg8_type cell_count;
    logic [`IRQ_USED_MSB:0] irq_status;
    logic [`IRQ_USED_MSB:0] irq_mask;
    logic [`PHASE_STAGES-1:0] reset_delay;
    reg8_type alarm_summary;
    channel_type sel_channel;
    logic sel_section_err;
    logic sel_cell_err;
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic rd_capture;
    logic lane0;
    logic [19:0] index;
    logic index_ok;
    logic mapped;
    apb_data_type read_value;
    logic rd_section;
    logic rd_cell;
    logic rd_status;
    logic tx_edge;
    logic [`IRQ_USED_MSB:0] irq_events;
    // register hits and write strobes
    logic hit_select;
    logic hit_reset;
    logic hit_tx;
    logic hit_section;
    logic hit_cell;
    logic hit_status;
    logic hit_mask;
    logic wr_select;
    logic wr_reset;
    logic wr_tx;
    logic wr_mask;
    logic section_full;
    logic cell_full;
    logic soft_reset_req;
    logic [1:0] reset_phase;
    logic any_alarm;
    logic irq_pending;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access = access_phase & pwrite & index_ok;
    // reads take effect at the edge that loads prdata, so no event is lost
    assign rd_capture = setup_phase & ~pwrite & index_ok;
    assign lane0 = pstrb[0];
    assign index = {2'b00, paddr[19:2]};
    assign index_ok = (paddr[1:0] == 2'b00) & mapped;
    assign pready = access_phase;

    always_comb begin
        mapped = 1'b1;
        read_value = 32'h0000_0000;
        unique case (index)
            `IDX_COUNTER_SELECT_AND_CELL_MODE: begin
                read_value[7:0] = select_mode;
            end
            `IDX_CORE_RESET_CONTROL: begin
                read_value[7:5] = reset_ctrl;
            end
            `IDX_TRANSMIT_SETUP_COMPLETE: begin
                read_value[`TX_DONE_BIT] = tx_done_bit;
            end
            `IDX_CHANNEL_ALARM_SUMMARY: begin
                read_value[7:0] = alarm_summary;
            end
            `IDX_SECTION_PARITY_ERROR_COUNT: begin
                read_value[7:0] = section_count;
            end
            `IDX_CELL_PARITY_ERROR_COUNT: begin
                read_value[7:0] = cell_count;
            end
            `IDX_IRQ_STATUS: begin
                read_value[`IRQ_USED_MSB:0] = irq_status;
            end
            `IDX_IRQ_MASK: begin
                read_value[`IRQ_USED_MSB:0] = irq_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : read_value;
            pslverr <= ~index_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register hits

    assign hit_select = (index == `IDX_COUNTER_SELECT_AND_CELL_MODE);
    assign hit_reset = (index == `IDX_CORE_RESET_CONTROL);
    assign hit_tx = (index == `IDX_TRANSMIT_SETUP_COMPLETE);
    assign hit_section = (index == `IDX_SECTION_PARITY_ERROR_COUNT);
    assign hit_cell = (index == `IDX_CELL_PARITY_ERROR_COUNT);
    assign hit_status = (index == `IDX_IRQ_STATUS);
    assign hit_mask = (index == `IDX_IRQ_MASK);

    assign wr_select = wr_access & lane0 & hit_select;
    assign wr_reset = wr_access & lane0 & hit_reset;
    assign wr_tx = wr_access & lane0 & hit_tx;
    assign wr_mask = wr_access & lane0 & hit_mask;

    assign rd_section = rd_capture & hit_section;
    assign rd_cell = rd_capture & hit_cell;
    assign rd_status = rd_capture & hit_status;

    ////////////////////////////////////////////////////////////////////////////
    // software registers, untouched by the soft reset

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            select_mode <= `RESET_REG8;
        end else if (wr_select) begin
            select_mode <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reset_ctrl <= 3'b000;
        end else if (wr_reset) begin
            reset_ctrl <= pwdata[7:5];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_done_bit <= 1'b0;
        end else if (wr_tx) begin
            tx_done_bit <= pwdata[`TX_DONE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_mask <= `RESET_IRQ_MASK;
        end else if (wr_mask) begin
            irq_mask <= pwdata[`IRQ_USED_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cell mode

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cell_all_enable <= 1'b0;
        end else begin
            cell_all_enable <= select_mode[`CELL_ALL_BIT];
        end
    end

    // one enable per channel pair, forced off in eight-link mode
    for (genvar pr = 0; pr < 4; pr++) begin : g_cell_pair
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                cell_pair_enable[pr] <= 1'b0;
            end else if (select_mode[`CELL_ALL_BIT]) begin
                cell_pair_enable[pr] <= 1'b0;
            end else begin
                cell_pair_enable[pr] <= select_mode[`CELL_PAIR_LSB + pr];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft reset with selectable delay phase

    assign soft_reset_req = reset_ctrl[2];
    assign reset_phase = reset_ctrl[1:0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reset_delay <= 4'h0;
        end else begin
            reset_delay <= {reset_delay[`PHASE_STAGES-2:0], soft_reset_req};
        end
    end

    // only the core output; serializer state and software registers stay
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_soft_reset <= 1'b0;
        end else begin
            core_soft_reset <= reset_delay[reset_phase];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit setup complete strobe

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_done_prev <= 1'b0;
        end else begin
            tx_done_prev <= tx_done_bit;
        end
    end

    assign tx_edge = tx_done_bit & ~tx_done_prev;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_setup_done <= 1'b0;
        end else begin
            tx_setup_done <= tx_edge;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm summary

    for (genvar ch = 0; ch < 8; ch++) begin : g_alarm
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                alarm_summary[7-ch] <= 1'b0;
            end else begin
                alarm_summary[7-ch] <= |alarm_status[ch*4 +: 4];
            end
        end
    end

    assign any_alarm = |alarm_summary;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarm_indication <= 1'b0;
        end else begin
            alarm_indication <= any_alarm;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error counters

    assign sel_channel = channel_type'(select_mode[`SEL_MSB:`SEL_LSB]);
    assign sel_section_err = section_error[sel_channel];
    assign sel_cell_err = cell_error[sel_channel];

    // counters hold at full scale instead of wrapping
    assign section_full = (section_count == `COUNT_MAX);
    assign cell_full = (cell_count == `COUNT_MAX);

    // an event at the capturing read edge starts the new count at one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            section_count <= `RESET_REG8;
        end else if (rd_section) begin
            section_count <= {7'h00, sel_section_err};
        end else if (sel_section_err & ~section_full) begin
            section_count <= section_count + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cell_count <= `RESET_REG8;
        end else if (rd_cell) begin
            cell_count <= {7'h00, sel_cell_err};
        end else if (sel_cell_err & ~cell_full) begin
            cell_count <= cell_count + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, cleared by read, set wins

    always_comb begin
        irq_events = 4'h0;
        irq_events[`IRQ_ALARM_BIT] = any_alarm;
        irq_events[`IRQ_SECTION_BIT] = sel_section_err;
        irq_events[`IRQ_CELL_BIT] = sel_cell_err;
        irq_events[`IRQ_TX_DONE_BIT] = tx_edge;
    end

    // per status bit the event wins over the clearing read
    for (genvar b = 0; b <= `IRQ_USED_MSB; b++) begin : g_irq_status
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                irq_status[b] <= 1'b0;
            end else if (irq_events[b]) begin
                irq_status[b] <= 1'b1;
            end else if (rd_status) begin
                irq_status[b] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt output

    assign irq_pending = |(irq_status & irq_mask);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_pending;
        end
    end

endmodule
`default_nettype wire

//--- shared/core_common_defs.svh
// offsets, field positions, reset values and timing counts of the common registers
`ifndef CORE_COMMON_DEFS_SVH
`define CORE_COMMON_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_COUNTER_SELECT_AND_CELL_MODE 20'h30A05
`define IDX_CORE_RESET_CONTROL 20'h30A06
`define IDX_TRANSMIT_SETUP_COMPLETE 20'h30A07
`define IDX_CHANNEL_ALARM_SUMMARY 20'h30A08
`define IDX_SECTION_PARITY_ERROR_COUNT 20'h30A09
`define IDX_CELL_PARITY_ERROR_COUNT 20'h30A0A
`define IDX_IRQ_STATUS 20'h30A10
`define IDX_IRQ_MASK 20'h30A11

// field positions
`define SEL_LSB 0
`define SEL_MSB 2
`define CELL_PAIR_LSB 3
`define CELL_PAIR_MSB 6
`define CELL_ALL_BIT 7
`define PHASE_LSB 5
`define PHASE_MSB 6
`define SOFT_RESET_BIT 7
`define TX_DONE_BIT 7

// interrupt status bits
`define IRQ_ALARM_BIT 0
`define IRQ_SECTION_BIT 1
`define IRQ_CELL_BIT 2
`define IRQ_TX_DONE_BIT 3
`define IRQ_USED_MSB 3

// reset values
`define RESET_REG8 8'h00
`define RESET_IRQ_MASK 4'h0

// timing
`define PHASE_STAGES 4
`define COUNT_MAX 8'hFF
`define ALARM_BITS_PER_CHANNEL 4

`endif

//--- shared/core_common_pkg.sv
// types shared by the common control and status block
`default_nettype none
package core_common_pkg;
    typedef enum logic [2:0] {
        chan_aa,
        chan_ab,
        chan_ac,
        chan_ad,
        chan_ba,
        chan_bb,
        chan_bc,
        chan_bd
    } channel_type;
    typedef logic [7:0] reg8_type;
    typedef logic [19:0] apb_addr_type;
    typedef logic [31:0] apb_data_type;
endpackage
`default_nettype wire

//--- sim/core_common_regs_chk.sv
// assertion checker for the common control and status registers
`include "core_common_defs.svh"
`default_nettype none
module core_common_regs_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire core_common_pkg::apb_addr_type paddr,
    input wire core_common_pkg::apb_data_type pwdata,
    input wire logic [3:0] pstrb,
    // core side
    input wire logic [31:0] alarm_status,
    input wire logic [3:0] cell_pair_enable,
    input wire logic cell_all_enable,
    input wire logic core_soft_reset,
    input wire logic tx_setup_done,
    input wire logic alarm_indication,
    input wire logic irq
);
    import core_common_pkg::*;
    logic wr, w_mode, w_rst, w_tx;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign w_mode = wr && paddr == `IDX_COUNTER_SELECT_AND_CELL_MODE << 2;
    assign w_rst = wr && paddr == `IDX_CORE_RESET_CONTROL << 2;
    assign w_tx = wr && paddr == `IDX_TRANSMIT_SETUP_COMPLETE << 2;
    ////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_all_clears_pairs: assert property (cell_all_enable |-> cell_pair_enable == 4'h0)
        else $error("pair enables in eight-link mode");
    a_mode_pairs: assert property (w_mode && !pwdata[7] |-> ##2
        cell_pair_enable == $past(pwdata[6:3], 2)) else $error("pair enables wrong");
    a_mode_all: assert property (w_mode |-> ##2 cell_all_enable == $past(pwdata[7], 2))
        else $error("eight-link enable wrong");
    a_alarm_or: assert property (!$past(rst) && !$past(rst, 2) |->
        alarm_indication == (|$past(alarm_status, 2))) else $error("alarm indication wrong");
    a_tx_cause: assert property (tx_setup_done |-> $past(w_tx && pwdata[7], 2) ||
        $past(w_tx && pwdata[7], 3)) else $error("setup pulse without write");
    a_tx_pulse: assert property (tx_setup_done |=> !tx_setup_done)
        else $error("setup pulse too long");
    a_reset_phase0: assert property (w_rst && pwdata[7:5] == 3'h4 && !core_soft_reset
        |-> !core_soft_reset [*3] ##1 core_soft_reset) else $error("soft reset phase 0 late");
    a_reset_phase3: assert property (w_rst && pwdata[7:5] == 3'h7 && !core_soft_reset
        |-> !core_soft_reset [*6] ##1 core_soft_reset) else $error("soft reset phase 3 late");
    c_tx: cover property (tx_setup_done);
    c_soft: cover property ($rose(core_soft_reset));
    c_irq: cover property (irq);
endmodule
bind core_common_regs core_common_regs_chk core_common_regs_chk_inst (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .alarm_status,
    .cell_pair_enable, .cell_all_enable, .core_soft_reset, .tx_setup_done,
    .alarm_indication, .irq
);
`default_nettype wire

//--- sim/core_common_regs_tb_top.sv
// self-checking bench for the common control and status registers
`include "core_common_defs.svh"
`default_nettype none
module core_common_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import core_common_pkg::*;
    localparam apb_addr_type i_sel = `IDX_COUNTER_SELECT_AND_CELL_MODE;
    localparam apb_addr_type i_rst = `IDX_CORE_RESET_CONTROL;
    localparam apb_addr_type i_tx = `IDX_TRANSMIT_SETUP_COMPLETE;
    localparam apb_addr_type i_sum = `IDX_CHANNEL_ALARM_SUMMARY;
    localparam apb_addr_type i_sec = `IDX_SECTION_PARITY_ERROR_COUNT;
    localparam apb_addr_type i_cel = `IDX_CELL_PARITY_ERROR_COUNT;
    localparam apb_addr_type i_irq = `IDX_IRQ_STATUS;
    localparam apb_addr_type i_msk = `IDX_IRQ_MASK;
    localparam apb_addr_type all_idx [8] = '{i_sel, i_rst, i_tx, i_sum, i_sec, i_cel, i_irq,
        i_msk};
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
    apb_addr_type paddr;
    apb_data_type pwdata, prdata, rd;
    logic [7:0] section_error, cell_error;
    logic [31:0] alarm_status;
    logic [3:0] cell_pair_enable;
    logic cell_all_enable, core_soft_reset, tx_setup_done, alarm_indication, irq;
    int num_errors, compares;
    core_common_regs core_common_regs_inst (
        .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .pready, .prdata, .pslverr, .section_error, .cell_error, .alarm_status,
        .cell_pair_enable, .cell_all_enable, .core_soft_reset, .tx_setup_done,
        .alarm_indication, .irq
    );
    ////////////////////////////////////////////////
    function automatic reg8_type sum_exp(input logic [31:0] a);
        reg8_type r;
        for (int i = 0; i < 8; i++) begin
            r[7 - i] = |a[4 * i +: 4];
        end
        return r;
    endfunction
    function automatic logic [4:0] mode_exp(input reg8_type m);
        return {m[7], m[7] ? 4'h0 : m[6:3]};
    endfunction
    task automatic cmp_word(input apb_data_type got, input apb_data_type exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input apb_addr_type idx, input reg8_type d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= idx << 2;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input apb_addr_type idx, input reg8_type exp);
        xfer(1'b0, idx, 8'h00);
        cmp_word(rd, {24'h0, exp});
        cmp_bit(er, 1'b0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cnt_tx(input int exp);
        int n;
        n = 0;
        repeat (6) begin
            cyc(1);
            n += (tx_setup_done === 1'b1);
        end
        cmp_word(32'(n), 32'(exp));
    endtask
    task automatic pulse_sec(input reg8_type b);
        @(posedge sys_clk);
        section_error <= b;
        @(posedge sys_clk);
        section_error <= 8'h00;
        cyc(3);
    endtask
    task automatic finish_test;
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end
    initial begin
        reg8_type v;
        int n, m;
        logic hs, hc;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 55'h0};
        {section_error, cell_error, alarm_status} = 48'h0;
        void'($urandom(32'hADA40990));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (all_idx[i]) rd_chk(all_idx[i], 8'h00);
        xfer(1'b0, 20'h30A20, 8'h00);
        cmp_bit(er, 1'b1);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hF8 : (i == 1) ? 8'h78 : 8'($urandom);
            xfer(1'b1, i_sel, v);
            cyc(2);
            cmp_word({cell_all_enable, cell_pair_enable}, mode_exp(v));
            rd_chk(i_sel, v);
        end
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, i_sel, 8'(c));
            xfer(1'b0, i_sec, 8'h00);
            xfer(1'b0, i_cel, 8'h00);
            n = 0;
            m = 0;
            repeat (6) begin
                @(posedge sys_clk);
                hs = 1'($urandom);
                hc = 1'($urandom);
                section_error <= (8'($urandom) & ~(8'h01 << c)) | (8'(hs) << c);
                cell_error <= (8'($urandom) & ~(8'h01 << c)) | (8'(hc) << c);
                n += hs;
                m += hc;
            end
            @(posedge sys_clk);
            section_error <= 8'h00;
            cell_error <= 8'h00;
            cyc(2);
            rd_chk(i_sec, 8'(n));
            rd_chk(i_cel, 8'(m));
            rd_chk(i_sec, 8'h00);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            alarm_status <= (k == 0) ? 32'h0 : (k == 1) ? 32'h80000001 : $urandom;
            cyc(3);
            cmp_bit(alarm_indication, |alarm_status);
            rd_chk(i_sum, sum_exp(alarm_status));
        end
        @(posedge sys_clk);
        alarm_status <= 32'h0;
        for (int p = 0; p < 4; p++) begin
            xfer(1'b1, i_rst, {1'b1, 2'(p), 5'h0});
            cyc(p + 1);
            cmp_bit(core_soft_reset, 1'b0);
            cyc(1);
            cmp_bit(core_soft_reset, 1'b1);
            rd_chk(i_sel, 8'h07);
            rd_chk(i_rst, {1'b1, 2'(p), 5'h0});
            xfer(1'b1, i_rst, {1'b0, 2'(p), 5'h0});
            cyc(8);
            cmp_bit(core_soft_reset, 1'b0);
        end
        xfer(1'b1, i_tx, 8'h00);
        xfer(1'b1, i_tx, 8'h80);
        cnt_tx(1);
        xfer(1'b1, i_tx, 8'h80);
        cnt_tx(0);
        xfer(1'b1, i_msk, 8'h02);
        xfer(1'b0, i_irq, 8'h00);
        cyc(2);
        cmp_bit(irq, 1'b0);
        xfer(1'b1, i_sel, 8'h03);
        pulse_sec(8'h08);
        cmp_bit(irq, 1'b1);
        rd_chk(i_irq, 8'h02);
        cyc(2);
        cmp_bit(irq, 1'b0);
        xfer(1'b1, i_msk, 8'h00);
        pulse_sec(8'h08);
        cmp_bit(irq, 1'b0);
        rd_chk(i_irq, 8'h02);
        finish_test();
    end
endmodule
`default_nettype wire
